/* File: fec_bus_cycle.sv */
// One flash bus cycle: a write pulse or a read with synchronised capture.
// Assumes dq_in comes from the flash pins, asynchronous to ref_clk.
`timescale 1ns/1ps
module fec_bus_cycle #(
   parameter int WE_LOW_CYC = 3,
   parameter int HOLD_CYC   = 2,
   parameter int RD_CYC     = 5
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              start,
   input  wire fec_pkg::fec_req_t req,
   input  wire logic [7:0]        dq_in,
   output fec_pkg::fec_pins_t     pins,
   output logic [7:0]             rdata,
   output logic                   done
);

   typedef enum logic [1:0] {BC_IDLE, BC_PULSE, BC_HOLD} fec_bc_state_t;

   fec_bc_state_t state;
   logic [7:0]    cnt;
   logic          is_wr;
   logic [7:0]    dq_meta;
   logic [7:0]    dq_sync;

   // Sync delay is added so the captured byte reflects the driven address
   wire [7:0] pulse_len = is_wr ? 8'(WE_LOW_CYC) : 8'(RD_CYC + 2);
   wire       last     = (cnt == pulse_len - 8'h01);

   always_ff @(posedge ref_clk)
   begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
   end

   always_ff @(posedge ref_clk)
   begin
      done <= 1'b0;
      if (rst)
      begin
         state <= BC_IDLE;
         cnt   <= 8'h00;
         is_wr <= 1'b0;
         rdata <= 8'h00;
         pins  <= '{1'b1, 1'b1, 1'b1, 17'h00000, 8'h00, 1'b0};
      end
      else
      begin
         case (state)
            BC_IDLE:
               if (start)
               begin
                  // Start of cycle: select low; a write drops the strobe, a read drops output enable
                  is_wr                <= req.wr;
                  cnt                  <= 8'h00;
                  pins.addr            <= req.addr;
                  pins.dq_out          <= req.data;
                  pins.dq_oe           <= req.wr;
                  pins.chip_select_n   <= 1'b0;
                  pins.output_enable_n <= req.wr;
                  pins.write_strobe_n  <= ~req.wr;
                  state                <= BC_PULSE;
               end
            BC_PULSE:
            begin
               cnt <= cnt + 8'h01;
               if (last)
               begin
                  // Data and address stay put past the rising strobe edge
                  pins.write_strobe_n  <= 1'b1;
                  pins.output_enable_n <= 1'b1;
                  if (!is_wr)
                     rdata <= dq_sync;
                  cnt   <= 8'h00;
                  state <= BC_HOLD;
               end
            end
            default:
            begin
               cnt <= cnt + 8'h01;
               if (cnt == 8'(HOLD_CYC - 1))
               begin
                  pins.chip_select_n <= 1'b1;
                  pins.dq_oe         <= 1'b0;
                  done               <= 1'b1;
                  state              <= BC_IDLE;
               end
            end
         endcase
      end
   end

endmodule : fec_bus_cycle

/* File: fec_controller.sv */
// Host-side controller for sector erase, suspend/resume and byte program.
// Assumes software on AXI4-Lite and a byte-wide flash on the pin bundle.
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module fec_controller #(
   parameter logic [16:0] UNLOCK_ADDR1 = 17'h00001,
   parameter logic [16:0] UNLOCK_ADDR2 = 17'h00002,
   parameter logic [7:0]  UNLOCK_DATA1 = 8'h01,
   parameter logic [7:0]  UNLOCK_DATA2 = 8'h02,
   parameter int          WE_LOW_CYC   = 3,
   parameter int          HOLD_CYC     = 2,
   parameter int          RD_CYC       = 5
) (
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   input  wire logic [7:0]    dq_in,
   output fec_pkg::fec_pins_t flash
);

   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} fec_state_t;

   fec_state_t        state;
   fec_pkg::fec_op_t  op;
   logic [16:0]       addr_reg;
   logic [7:0]        data_reg;
   logic [2:0]        idx;
   logic [1:0]        phase;
   logic [7:0]        first_rd;
   logic [7:0]        last_rd;
   logic              bus_start;
   logic              ok;
   logic              fail;
   logic              refused;
   logic              locked;
   logic              erasing;
   logic              suspended;
   logic              window;
   logic [10:0]       win_cnt;
   logic              start_req;
   logic [3:0]        start_op;
   logic [7:0]        bus_rdata;
   logic              bus_done;
   fec_pkg::fec_req_t bus_req;

   // ----------------------------------------------------------------------
   // Command sequences
   // ----------------------------------------------------------------------
   function automatic fec_pkg::fec_req_t seq_word(input fec_pkg::fec_op_t o,
                                                 input logic [2:0] i,
                                                 input logic [16:0] a,
                                                 input logic [7:0] d);
      fec_pkg::fec_req_t r;
      r = '{1'b1, a, fec_pkg::CMD_SECTOR};
      case (o)
         fec_pkg::FEC_OP_PROGRAM:
            case (i)
               3'd0:    r = '{1'b1, UNLOCK_ADDR1, UNLOCK_DATA1};
               3'd1:    r = '{1'b1, UNLOCK_ADDR2, UNLOCK_DATA2};
               3'd2:    r = '{1'b1, UNLOCK_ADDR1, fec_pkg::CMD_PROGRAM};
               default: r = '{1'b1, a, d};
            endcase
         fec_pkg::FEC_OP_ERASE:
            case (i)
               3'd0, 3'd3: r = '{1'b1, UNLOCK_ADDR1, UNLOCK_DATA1};
               3'd1, 3'd4: r = '{1'b1, UNLOCK_ADDR2, UNLOCK_DATA2};
               3'd2:       r = '{1'b1, UNLOCK_ADDR1, fec_pkg::CMD_SETUP_ERASE};
               default:    r = '{1'b1, a, fec_pkg::CMD_SECTOR};
            endcase
         fec_pkg::FEC_OP_SUSPEND: r = '{1'b1, a, fec_pkg::CMD_SUSPEND};
         fec_pkg::FEC_OP_RESUME:  r = '{1'b1, a, fec_pkg::CMD_RESUME};
         fec_pkg::FEC_OP_RESET:   r = '{1'b1, a, fec_pkg::CMD_RESET};
         default:                 r = '{1'b1, a, fec_pkg::CMD_SECTOR};
      endcase
      return r;
   endfunction : seq_word

   wire [2:0] n_writes = (op == fec_pkg::FEC_OP_PROGRAM) ? 3'd4 :
                         (op == fec_pkg::FEC_OP_ERASE)   ? 3'd6 :
                         (op == fec_pkg::FEC_OP_READ ||
                          op == fec_pkg::FEC_OP_POLL)    ? 3'd0 : 3'd1;
   wire       needs_poll = (op == fec_pkg::FEC_OP_PROGRAM) ||
                           (op == fec_pkg::FEC_OP_SUSPEND) ||
                           (op == fec_pkg::FEC_OP_POLL);
   wire [2:0] next_idx   = idx + 3'd1;

   // Refusals keep the flash from seeing a sequence it would abort
   wire refuse_now =
      (start_op == fec_pkg::FEC_OP_PROGRAM &&
       (locked || (erasing && !suspended))) ||
      (start_op == fec_pkg::FEC_OP_ERASE && (locked || erasing)) ||
      (start_op == fec_pkg::FEC_OP_ADD && !window) ||
      (start_op == fec_pkg::FEC_OP_SUSPEND && (!erasing || suspended)) ||
      (start_op == fec_pkg::FEC_OP_RESUME && !suspended) ||
      (start_op == fec_pkg::FEC_OP_POLL && (!erasing || suspended)) ||
      (start_op > fec_pkg::FEC_OP_POLL);

   // Read phases drive the user address; status reads answer anywhere
   wire fec_pkg::fec_req_t cur_req = (phase == 2'd0) ?
      seq_word(op, idx, addr_reg, data_reg) : fec_pkg::fec_req_t'{1'b0, addr_reg, 8'h00};

   wire stopped    = (first_rd[fec_pkg::TOGGLE_STATUS_BIT] ==
                      bus_rdata[fec_pkg::TOGGLE_STATUS_BIT]);
   wire timed_out  = first_rd[fec_pkg::TIME_LIMIT_FLAG] &
                     bus_rdata[fec_pkg::TIME_LIMIT_FLAG];
   wire prog_match = (bus_rdata[7:6] == data_reg[7:6]);

   // ----------------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------------
   wire aw_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   wire ar_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   wire wr_ctrl = aw_take && s_axi_awaddr == fec_pkg::REG_CTRL && s_axi_wstrb[0];
   wire wr_addr = aw_take && s_axi_awaddr == fec_pkg::REG_ADDR;
   wire wr_data = aw_take && s_axi_awaddr == fec_pkg::REG_DATA && s_axi_wstrb[0];
   wire known_w = (s_axi_awaddr == fec_pkg::REG_CTRL) ||
                  (s_axi_awaddr == fec_pkg::REG_ADDR) ||
                  (s_axi_awaddr == fec_pkg::REG_DATA);

   wire [31:0] status_word = {16'h0000, last_rd, suspended, erasing, window, locked,
                              refused, fail, ok, state != ST_IDLE};
   wire [31:0] rd_word;
   wire        rd_known;
   assign rd_known = (s_axi_araddr == fec_pkg::REG_CTRL) ||
                     (s_axi_araddr == fec_pkg::REG_ADDR) ||
                     (s_axi_araddr == fec_pkg::REG_DATA) ||
                     (s_axi_araddr == fec_pkg::REG_STATUS);
   assign rd_word  = (s_axi_araddr == fec_pkg::REG_CTRL)   ? {28'h0000000, op} :
                     (s_axi_araddr == fec_pkg::REG_ADDR)   ? {15'h0000, addr_reg} :
                     (s_axi_araddr == fec_pkg::REG_DATA)   ? {24'h000000, data_reg} :
                     (s_axi_araddr == fec_pkg::REG_STATUS) ? status_word : 32'h00000000;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'h0;
         s_axi_rdata   <= 32'h00000000;
      end
      else
      begin
         s_axi_awready <= aw_take;
         s_axi_wready  <= aw_take;
         s_axi_arready <= ar_take;
         if (aw_take)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known_w ? 2'h0 : 2'h2;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (ar_take)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_known ? 2'h0 : 2'h2;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   assign start_req = wr_ctrl;
   assign start_op  = s_axi_wdata[fec_pkg::CTRL_OP_MSB:fec_pkg::CTRL_OP_LSB];

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      bus_start <= 1'b0;
      if (rst)
      begin
         state     <= ST_IDLE;
         op        <= fec_pkg::FEC_OP_READ;
         addr_reg  <= fec_pkg::ADDR_RST;
         data_reg  <= fec_pkg::DATA_RST;
         idx       <= 3'd0;
         phase     <= 2'd0;
         first_rd  <= 8'h00;
         last_rd   <= 8'h00;
         bus_req   <= '{1'b0, 17'h00000, 8'h00};
         {ok, fail, refused, locked, erasing, suspended, window} <= 7'h00;
         win_cnt   <= 11'h000;
      end
      else
      begin
         if (wr_addr && state == ST_IDLE)
            addr_reg <= s_axi_wdata[16:0];
         if (wr_data && state == ST_IDLE)
            data_reg <= s_axi_wdata[7:0];
         // Load window: flash closes it and begins the erase on expiry
         if (window)
         begin
            win_cnt <= win_cnt + 11'h001;
            if (win_cnt == fec_pkg::WIN_END)
               window <= 1'b0;
         end
         case (state)
            ST_IDLE:
               if (start_req)
               begin
                  if (refuse_now || (start_op == fec_pkg::FEC_OP_ADD &&
                                     win_cnt >= fec_pkg::WIN_LIMIT))
                     refused <= 1'b1;
                  else
                  begin
                     op      <= fec_pkg::fec_op_t'(start_op);
                     {ok, fail, refused} <= 3'b000;
                     idx     <= 3'd0;
                     phase   <= (start_op == fec_pkg::FEC_OP_READ ||
                                 start_op == fec_pkg::FEC_OP_POLL) ? 2'd1 : 2'd0;
                     state   <= ST_ISSUE;
                  end
               end
            ST_ISSUE:
            begin
               bus_req   <= cur_req;
               bus_start <= 1'b1;
               state     <= ST_WAIT;
            end
            default:
               if (bus_done)
               begin
                  state <= ST_ISSUE;
                  if (phase == 2'd0)
                  begin
                     if (next_idx < n_writes)
                        idx <= next_idx;
                     else if (needs_poll)
                        phase <= 2'd1;
                     else
                     begin
                        state <= ST_IDLE;
                        ok    <= 1'b1;
                        case (op)
                           fec_pkg::FEC_OP_ERASE, fec_pkg::FEC_OP_ADD:
                           begin
                              // Flash now runs zero-fill and erase on its own
                              erasing <= 1'b1;
                              window  <= 1'b1;
                              win_cnt <= 11'h000;
                           end
                           fec_pkg::FEC_OP_RESUME:
                              suspended <= 1'b0;
                           fec_pkg::FEC_OP_RESET:
                           begin
                              // Clears the lock left by a time-limit failure
                              {locked, erasing, suspended, window} <= 4'h0;
                           end
                           default:
                              ok <= 1'b1;
                        endcase
                     end
                  end
                  else if (phase == 2'd1)
                  begin
                     first_rd <= bus_rdata;
                     last_rd  <= bus_rdata;
                     if (op == fec_pkg::FEC_OP_READ)
                     begin
                        state <= ST_IDLE;
                        ok    <= 1'b1;
                     end
                     else
                        phase <= 2'd2;
                  end
                  else
                  begin
                     first_rd <= bus_rdata;
                     last_rd  <= bus_rdata;
                     if (stopped) // Toggle bit equal on two reads
                     begin
                        state <= ST_IDLE;
                        if (op == fec_pkg::FEC_OP_SUSPEND)
                        begin
                           // Suspend ends the window; flash reads when ready
                           suspended <= 1'b1;
                           window    <= 1'b0;
                           ok        <= 1'b1;
                        end
                        else if (op == fec_pkg::FEC_OP_PROGRAM)
                        begin
                           ok   <= prog_match;
                           fail <= !prog_match;
                        end
                        else
                        begin
                           ok      <= bus_rdata[fec_pkg::DATA_POLL_BIT];
                           fail    <= !bus_rdata[fec_pkg::DATA_POLL_BIT];
                           erasing <= 1'b0;
                        end
                     end
                     else if (timed_out) // Still toggling with limit flag
                     begin
                        state  <= ST_IDLE;
                        fail   <= 1'b1;
                        locked <= 1'b1;
                     end
                  end
               end
         endcase
      end
   end

   fec_bus_cycle #(
      .WE_LOW_CYC (WE_LOW_CYC),
      .HOLD_CYC   (HOLD_CYC),
      .RD_CYC     (RD_CYC)
   ) u_cycle (
      .ref_clk (ref_clk),
      .rst     (rst),
      .start   (bus_start),
      .req     (bus_req),
      .dq_in   (dq_in),
      .pins    (flash),
      .rdata   (bus_rdata),
      .done    (bus_done)
   );

endmodule : fec_controller

/* File: fec_controller_bench.sv */
// Self-checking bench of the flash command controller over AXI4-Lite.
// Assumes the behavioural flash model answers on the pin bundle.
`timescale 1ns/1ps
module fec_controller_bench;
   logic               ref_clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0;
   logic               br = 1'h0, arv = 1'h0, rr = 1'h0, awr, wr_r, bv, arr, rv;
   logic [7:0]         awa = 8'h00, ara = 8'h00, dq;
   logic [31:0]        wd = 32'h0, rdd, st;
   logic [1:0]         bre, rre, rs;
   fec_pkg::fec_pins_t flash;
   int                 n_errors = 0, comparisons = 0;
   always #10 ref_clk = ~ref_clk;
   fec_controller dut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr_r), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd),
      .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr), .dq_in(dq), .flash(flash));
   fec_flash_model mdl (.flash(flash), .dq_in(dq));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic put(input logic [7:0] a, input logic [31:0] d);
      logic aw_done, w_done;
      {aw_done, w_done} = 2'h0;
      {awa, wd, awv, wv, br} <= {a, d, 3'h7};
      do
      begin
         @(posedge ref_clk);
         aw_done = aw_done | awr;
         w_done  = w_done | wr_r;
         awv <= !aw_done;
         wv  <= !w_done;
      end while (!bv);
      rs = bre;
      br <= 1'h0;
      @(posedge ref_clk);
   endtask : put
   task automatic get(input logic [7:0] a);
      {ara, arv, rr} <= {a, 2'h3};
      do @(posedge ref_clk); while (!arr);
      arv <= 1'h0;
      while (!rv) @(posedge ref_clk);
      {st, rs} = {rdd, rre};
      rr <= 1'h0;
      @(posedge ref_clk);
   endtask : get
   task automatic op(input fec_pkg::fec_op_t code);
      put(fec_pkg::REG_CTRL, {28'h0, code});
      st = 32'h1;
      while (st[fec_pkg::ST_BUSY] !== 1'h0) get(fec_pkg::REG_STATUS);
   endtask : op
   task automatic complete_run;
      if (n_errors == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run
   initial
   begin
      #1500000;
      n_errors++;
      complete_run();
   end
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'h0;
      get(fec_pkg::REG_STATUS);
      check(st[7:0], 8'h00);
      get(8'h10);
      check(8'(rs), 8'h02);
      put(8'h10, 32'h0);
      check(8'(rs), 8'h02);
      put(fec_pkg::REG_ADDR, 32'h100);
      put(fec_pkg::REG_DATA, 32'h5A);
      check(8'(rs), 8'h00);
      op(fec_pkg::FEC_OP_PROGRAM);
      check(st[7:0], 8'h02);
      check(mdl.mem[32'h100], 8'h5A);
      op(fec_pkg::FEC_OP_READ);
      check(st[15:8], 8'h5A);
      put(fec_pkg::REG_DATA, 32'hA5);
      op(fec_pkg::FEC_OP_PROGRAM);
      check(st[7:0], 8'h14);
      op(fec_pkg::FEC_OP_PROGRAM);
      check(st[7:0], 8'h1C);
      op(fec_pkg::FEC_OP_RESET);
      check(8'(st[4]), 8'h00);
      put(fec_pkg::REG_ADDR, 32'h10000);
      op(fec_pkg::FEC_OP_ERASE);
      check(st[7:0], 8'h62);
      check(8'(mdl.er), 8'h01);
      op(fec_pkg::FEC_OP_ADD);
      check(st[7:0], 8'h62);
      repeat (1500) @(posedge ref_clk);
      op(fec_pkg::FEC_OP_ADD);
      check(8'(st[5:3]), 8'h01);
      op(fec_pkg::FEC_OP_SUSPEND);
      check(8'(st[7:5]), 8'h06);
      put(fec_pkg::REG_ADDR, 32'h200);
      put(fec_pkg::REG_DATA, 32'h3C);
      op(fec_pkg::FEC_OP_PROGRAM);
      check(8'(st[3:1]), 8'h01);
      put(fec_pkg::REG_ADDR, 32'h10000);
      op(fec_pkg::FEC_OP_RESUME);
      check(8'(st[7]), 8'h00);
      op(fec_pkg::FEC_OP_RESUME);
      check(8'(st[3]), 8'h01);
      op(fec_pkg::FEC_OP_POLL);
      check(8'({st[6], st[2:1]}), 8'h01);
      op(fec_pkg::FEC_OP_SUSPEND);
      check(8'(st[3]), 8'h01);
      complete_run();
   end
endmodule : fec_controller_bench
bind fec_controller fec_controller_props chk (.ref_clk(ref_clk), .rst(rst), .flash(flash));

/* File: fec_controller_props.sv */
// Assertions on the flash pin bundle of the controller.
// Bound to fec_controller from the bench; sees its ports only.
`timescale 1ns/1ps
module fec_controller_props (
   input wire logic               ref_clk,
   input wire logic               rst,
   input wire fec_pkg::fec_pins_t flash
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence fall_s; $fell(flash.write_strobe_n); endsequence
   sequence held_s; $stable(flash.addr) && $stable(flash.dq_out) && flash.dq_oe; endsequence
   strobe_select_a: assert property (!flash.write_strobe_n |->
      !flash.chip_select_n && flash.output_enable_n) else $error("strobe without select");
   drive_select_a: assert property (flash.dq_oe |->
      !flash.chip_select_n && flash.output_enable_n) else $error("data driven off write");
   pins_held_a: assert property (fall_s |=> held_s [*4])
      else $error("address or data moved in write");
   rise_driven_a: assert property ($rose(flash.write_strobe_n) |->
      !flash.chip_select_n && flash.dq_oe) else $error("data gone at strobe rise");
   select_hold_a: assert property ($rose(flash.chip_select_n) |->
      $past(flash.write_strobe_n, 2)) else $error("select rose too soon");
endmodule : fec_controller_props

/* File: fec_flash_model.sv */
// Behavioural byte-wide flash on the host pin bundle.
// Assumes the controller drives fec_pins_t; reads come back on dq_in.
`timescale 1ns/1ps
module fec_flash_model (
   input  wire fec_pkg::fec_pins_t flash,
   output logic [7:0]              dq_in = 8'h00
);
   logic [7:0]  mem [int];
   logic [7:0]  d, last;
   logic [16:0] a;
   logic        tg = 1'h0, lim = 1'h0, er = 1'h0, sus = 1'h0, pg = 1'h0, pb = 1'h0;
   int          busy = 0, n = 0;
   always @(negedge flash.write_strobe_n) a = flash.addr;
   always @(posedge flash.write_strobe_n)
   begin
      d = flash.dq_out;
      if (pg)
      begin
         {pg, pb, lim, busy} = {2'h1, 1'(mem.exists(a)), 32'h4};
         mem[a] = d;
         last = d;
      end
      else if (d == fec_pkg::CMD_PROGRAM) pg = !lim;
      else if (d == fec_pkg::CMD_SETUP_ERASE) n = 1;
      else if (d == fec_pkg::CMD_SECTOR && (n == 1 || er))
         {er, sus, pb, busy, n} = {3'h4, 32'h6, 32'h0};
      else if (d == fec_pkg::CMD_SUSPEND && er && !sus)
         {sus, busy} = {1'h1, 32'h2};
      else if (d == fec_pkg::CMD_RESET) {lim, er, sus, busy} = 35'h0;
      else if (d > 8'h02) n = 0;
   end
   always @(negedge flash.output_enable_n)
   begin
      if (busy > 0)
         dq_in = {pb & ~last[7], tg, lim, 1'h0, er & ~sus, 3'h0};
      else
         dq_in = mem.exists(flash.addr) ? mem[flash.addr] : 8'hFF;
      tg = tg ^ (busy > 0);
      busy = (lim || busy == 0) ? busy : busy - 1;
   end
   // Released bus shows the inverse, never the last value
   always @(posedge flash.output_enable_n) dq_in = ~dq_in;
endmodule : fec_flash_model

/* File: fec_pkg.sv */
// Shared constants and carrier types of the flash command controller.
// Assumes a 50 MHz ref_clk and a byte-wide flash device on an async strobe bus.
package fec_pkg;

   // ----------------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_DATA   = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;

   // Control field: operation code in bits 3:0, written to start
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_OP_MSB = 3;

   // Status field positions
   localparam int ST_BUSY    = 0;
   localparam int ST_OK      = 1;
   localparam int ST_FAIL    = 2;
   localparam int ST_REFUSED = 3;
   localparam int ST_LOCKED  = 4;
   localparam int ST_WINDOW  = 5;
   localparam int ST_ERASING = 6;
   localparam int ST_SUSPEND = 7;
   localparam int ST_RD_LSB  = 8;
   localparam int ST_RD_MSB  = 15;

   // Reset values
   localparam logic [16:0] ADDR_RST = 17'h00000;
   localparam logic [7:0]  DATA_RST = 8'h00;

   // ----------------------------------------------------------------------
   // Flash command codes and status bit positions
   // ----------------------------------------------------------------------
   localparam logic [7:0] CMD_SETUP_ERASE = 8'h80;
   localparam logic [7:0] CMD_SECTOR      = 8'h30;
   localparam logic [7:0] CMD_RESUME      = 8'h30;
   localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
   localparam logic [7:0] CMD_PROGRAM     = 8'hA0;
   localparam logic [7:0] CMD_RESET       = 8'hF0;

   localparam int DATA_POLL_BIT     = 7;
   localparam int TOGGLE_STATUS_BIT = 6;
   localparam int TIME_LIMIT_FLAG   = 5;
   localparam int ERASE_WINDOW_FLAG = 3;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_MHZ        = 50;
   localparam int LOAD_WINDOW_US = 30;
   localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_US * CLK_MHZ;
   localparam int WIN_MARGIN_CYC = 64;
   localparam logic [10:0] WIN_LIMIT = 11'(LOAD_WINDOW_CYC - WIN_MARGIN_CYC);
   localparam logic [10:0] WIN_END   = 11'(LOAD_WINDOW_CYC - 1);

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      FEC_OP_READ    = 4'h0,
      FEC_OP_PROGRAM = 4'h1,
      FEC_OP_ERASE   = 4'h2,
      FEC_OP_ADD     = 4'h3,
      FEC_OP_SUSPEND = 4'h4,
      FEC_OP_RESUME  = 4'h5,
      FEC_OP_RESET   = 4'h6,
      FEC_OP_POLL    = 4'h7
   } fec_op_t;

   typedef struct packed {
      logic        wr;
      logic [16:0] addr;
      logic [7:0]  data;
   } fec_req_t;

   typedef struct packed {
      logic        chip_select_n;
      logic        output_enable_n;
      logic        write_strobe_n;
      logic [16:0] addr;
      logic [7:0]  dq_out;
      logic        dq_oe;
   } fec_pins_t;

endpackage : fec_pkg
